/* rtl/layer_color_key_and_palette.sv */
// Layer key colour transparency, colour table lookup and layer compositing
//
// How it works
// - Layers 1-5 hold 24-bit key; match is transparent
// - Eight-bit indirect compares only low key byte
// - Bit 31 set makes code zero opaque
// - Reset state: code zero black and transparent
// - Layer 1 YCbCr pixels never transparent
// - Short key registers alias extended key storage
// - Indirect code indexes the layer colour table
// - Layers 0-3 have 256-entry tables
// - Entry holds 6-bit RGB and bit 31; other bits zero
// - Entry bit 31 clear forbids blending
// - Tables at 400, 800, 1000, 1400 hex
// - Blend off means key colour overlay
// - Permit from entry MSB or pixel MSB
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module layer_color_key_and_palette
    import layer_key_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [12:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Pixels of all layers, one screen position per cycle
    input wire logic pixel_valid,
    input wire layer_pixel_t [NUM_LAYERS-1:0] pixel_in,
    input wire logic [NUM_LAYERS-1:0] blend_on,
    // Composited pixel
    output out_pixel_t pixel_out
);

    // Reset release synchroniser
    logic rst_meta;
    logic rst_sync_n;

    // Key colour storage, layers 1 to 5
    logic [23:0] key [1:NUM_LAYERS-1];
    logic zero_opaque [1:NUM_LAYERS-1];

    // Register decode
    logic [2:0] key_hit_layer;
    logic key_hit;
    logic short_hit;
    logic [2:0] short_layer;
    logic table_hit;
    logic [1:0] table_sel;
    logic [7:0] entry;

    // Read return
    rd_kind_t rd_kind;
    logic [1:0] rd_table;
    logic [31:0] rd_value;
    logic [31:0] next_rd_value;

    // Colour table ports
    logic [NUM_TABLES-1:0] table_we;
    logic [31:0] table_host_data [NUM_TABLES];
    logic [31:0] table_pix_data [NUM_TABLES];
    logic [31:0] table_wdata;

    // Pixel pipeline
    logic valid_s1;
    layer_pixel_t [NUM_LAYERS-1:0] pix_s1;
    logic [NUM_LAYERS-1:0] transparent;
    logic [NUM_LAYERS-1:0] blend_act;
    logic [23:0] colour [NUM_LAYERS];
    out_pixel_t next_out;

    // Reset is applied at once and released in step with the clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Address decode for key registers and short aliases
    always_comb begin
        key_hit = 1'b1;
        case (reg_addr)
            KEY_L1_OFFSET: key_hit_layer = 3'd1;
            KEY_L2_OFFSET: key_hit_layer = 3'd2;
            KEY_L3_OFFSET: key_hit_layer = 3'd3;
            KEY_L4_OFFSET: key_hit_layer = 3'd4;
            KEY_L5_OFFSET: key_hit_layer = 3'd5;
            default: begin
                key_hit = 1'b0;
                key_hit_layer = 3'd0;
            end
        endcase
        short_hit = 1'b1;
        case (reg_addr)
            SHORT_L2_OFFSET: short_layer = 3'd2;
            SHORT_L3_OFFSET: short_layer = 3'd3;
            default: begin
                short_hit = 1'b0;
                short_layer = 3'd0;
            end
        endcase
    end

    // Table windows; any address inside a window maps word-wise
    always_comb begin
        table_hit = 1'b1;
        case (reg_addr[WIN_MSB:WIN_LSB])
            TABLE_L0_OFFSET[WIN_MSB:WIN_LSB]: table_sel = 2'd0;
            TABLE_L1_OFFSET[WIN_MSB:WIN_LSB]: table_sel = 2'd1;
            TABLE_L2_OFFSET[WIN_MSB:WIN_LSB]: table_sel = 2'd2;
            TABLE_L3_OFFSET[WIN_MSB:WIN_LSB]: table_sel = 2'd3;
            default: begin
                table_hit = 1'b0;
                table_sel = 2'd0;
            end
        endcase
        entry = reg_addr[ENTRY_LSB +: TABLE_AW];
    end

    // Unused bits are never stored, so they read back as zero
    assign table_wdata = reg_wdata & TABLE_KEEP_MASK;

    // One write enable per table
    always_comb begin
        table_we = '0;
        if (reg_write && table_hit) begin
            table_we[table_sel] = 1'b1;
        end
    end

    // Key registers; the short view reaches the same flops
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int l = 1; l < NUM_LAYERS; l++) begin
                key[l] <= KEY_RESET;
                zero_opaque[l] <= ZERO_OPAQUE_RESET;
            end
        end else if (reg_write) begin
            for (int l = 1; l < NUM_LAYERS; l++) begin
                if (key_hit && key_hit_layer == 3'(l)) begin
                    key[l] <= reg_wdata[KEY_W-1:0];
                    zero_opaque[l] <= reg_wdata[ZERO_OPAQUE_BIT];
                end
                if (short_hit && short_layer == 3'(l)) begin
                    key[l][SHORT_W-1:0] <= reg_wdata[SHORT_W-1:0];
                    zero_opaque[l] <= reg_wdata[SHORT_ZERO_BIT];
                end
            end
        end
    end

    // Value of a plain register read, captured for the next cycle
    always_comb begin
        next_rd_value = '0;
        for (int l = 1; l < NUM_LAYERS; l++) begin
            if (key_hit && key_hit_layer == 3'(l)) begin
                next_rd_value[KEY_W-1:0] = key[l];
                next_rd_value[ZERO_OPAQUE_BIT] = zero_opaque[l];
            end
            if (short_hit && short_layer == 3'(l)) begin
                next_rd_value[SHORT_W-1:0] = key[l][SHORT_W-1:0];
                next_rd_value[SHORT_ZERO_BIT] = zero_opaque[l];
            end
        end
    end

    // Read tracking; unmapped addresses answer zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_kind <= RD_IDLE;
            rd_table <= 2'd0;
            rd_value <= '0;
        end else begin
            rd_value <= next_rd_value;
            rd_table <= table_sel;
            if (!reg_read) begin
                rd_kind <= RD_IDLE;
            end else if (table_hit) begin
                rd_kind <= RD_TABLE;
            end else begin
                rd_kind <= RD_REG;
            end
        end
    end

    // Table data already sit in the memory's output flops
    always_comb begin
        case (rd_kind)
            RD_TABLE: reg_rdata = table_host_data[rd_table];
            RD_REG: reg_rdata = rd_value;
            default: reg_rdata = '0;
        endcase
    end

    // Stage 1: register pixels so they line up with table lookups
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            valid_s1 <= 1'b0;
            pix_s1 <= '0;
        end else begin
            valid_s1 <= pixel_valid;
            pix_s1 <= pixel_in;
        end
    end

    // Colour tables, one per lower layer
    generate
        for (genvar t = 0; t < NUM_TABLES; t++) begin : g_table
            colour_table_mem u_table (
                .clk(clk),
                .we(table_we[t]),
                .waddr(entry),
                .wdata(table_wdata),
                .host_addr(entry),
                .host_data(table_host_data[t]),
                .pix_addr(pixel_in[t].code[CODE8_W-1:0]),
                .pix_data(table_pix_data[t])
            );
        end
    endgenerate

    // Per-layer colour, transparency and blend permission
    generate
        for (genvar i = 0; i < NUM_LAYERS; i++) begin : g_layer
            logic use_table;
            logic permit;
            logic code_zero;
            logic key_match;

            // Layers 4 and 5 have no table; their code is shown as is
            if (i < NUM_TABLES) begin : g_tab
                assign use_table = pix_s1[i].indirect;
                assign colour[i] = use_table ?
                    table_pix_data[i][KEY_W-1:0] : pix_s1[i].code;
                assign permit = use_table ?
                    table_pix_data[i][ALPHA_BIT] : pix_s1[i].direct_alpha;
            end else begin : g_direct
                assign use_table = 1'b0;
                assign colour[i] = pix_s1[i].code;
                assign permit = pix_s1[i].direct_alpha;
            end

            // Layer 0 is the background and has no key here
            if (i == 0) begin : g_base
                assign code_zero = 1'b0;
                assign key_match = 1'b0;
                assign transparent[i] = 1'b0;
            end else begin : g_keyed
                // Indirect pixels compare only the low byte of the key
                assign code_zero = pix_s1[i].indirect ?
                    (pix_s1[i].code[CODE8_W-1:0] == 8'h00) :
                    (pix_s1[i].code == 24'h00_0000);
                assign key_match = pix_s1[i].indirect ?
                    (pix_s1[i].code[CODE8_W-1:0] == key[i][CODE8_W-1:0]) :
                    (pix_s1[i].code == key[i]);
                if (i == 1) begin : g_yuv
                    // Video data carries no colour codes, so no keying
                    assign transparent[i] = pix_s1[i].ycbcr ? 1'b0 :
                        (code_zero ? !zero_opaque[i] : key_match);
                end else begin : g_rgb
                    assign transparent[i] =
                        code_zero ? !zero_opaque[i] : key_match;
                end
            end

            // Blending needs both the layer mode and the pixel's permit
            assign blend_act[i] = blend_on[i] & permit;
        end
    endgenerate

    // Topmost opaque layer wins; transparent ones reveal those beneath
    always_comb begin
        next_out.valid = valid_s1;
        next_out.layer = 3'd0;
        next_out.blend = blend_act[0];
        next_out.colour = colour[0];
        for (int l = 1; l < NUM_LAYERS; l++) begin
            if (!transparent[l]) begin
                next_out.layer = 3'(l);
                next_out.blend = blend_act[l];
                next_out.colour = colour[l];
            end
        end
    end

    // Stage 2: output register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pixel_out <= '0;
        end else begin
            pixel_out <= next_out;
        end
    end

endmodule

/* rtl/layer_key_pkg.sv */
// Shared constants and carrier types for layer key colour and colour table logic
package layer_key_pkg;

    // Geometry of the layer stack
    localparam int NUM_LAYERS = 6;
    localparam int NUM_TABLES = 4;
    localparam int TABLE_DEPTH = 256;
    localparam int TABLE_AW = 8;
    localparam int ADDR_W = 13;
    localparam int KEY_W = 24;
    localparam int SHORT_W = 15;
    localparam int CODE8_W = 8;

    // Register offsets above the display base address
    localparam logic [12:0] KEY_L1_OFFSET = 13'h01a4;
    localparam logic [12:0] KEY_L2_OFFSET = 13'h01a8;
    localparam logic [12:0] KEY_L3_OFFSET = 13'h01ac;
    localparam logic [12:0] KEY_L4_OFFSET = 13'h01b0;
    localparam logic [12:0] KEY_L5_OFFSET = 13'h01b4;
    localparam logic [12:0] SHORT_L3_OFFSET = 13'h00c0;
    localparam logic [12:0] SHORT_L2_OFFSET = 13'h00c2;

    // Colour table windows, selected by address bits 12 to 10
    localparam logic [12:0] TABLE_L0_OFFSET = 13'h0400;
    localparam logic [12:0] TABLE_L1_OFFSET = 13'h0800;
    localparam logic [12:0] TABLE_L2_OFFSET = 13'h1000;
    localparam logic [12:0] TABLE_L3_OFFSET = 13'h1400;
    localparam int WIN_LSB = 10;
    localparam int WIN_MSB = 12;
    localparam int ENTRY_LSB = 2;

    // Field positions
    localparam int ZERO_OPAQUE_BIT = 31;
    localparam int SHORT_ZERO_BIT = 15;
    localparam int ALPHA_BIT = 31;

    // Stored bits of a table entry: alpha, red, green, blue
    localparam logic [31:0] TABLE_KEEP_MASK = 32'h80fc_fcfc;

    // Reset values
    localparam logic [23:0] KEY_RESET = 24'h00_0000;
    localparam logic ZERO_OPAQUE_RESET = 1'b0;

    // One layer's pixel as it enters the block
    typedef struct packed {
        logic indirect;
        logic ycbcr;
        logic direct_alpha;
        logic [23:0] code;
    } layer_pixel_t;

    // Composited pixel leaving the block
    typedef struct packed {
        logic valid;
        logic [2:0] layer;
        logic blend;
        logic [23:0] colour;
    } out_pixel_t;

    // What the pending read answers with
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_REG = 2'b01,
        RD_TABLE = 2'b10
    } rd_kind_t;

endpackage

/* rtl/colour_table_mem.sv */
// One 256-entry colour table with a host port and a pixel read port
`timescale 1ns/1ps
module colour_table_mem
    import layer_key_pkg::*;
(
    // Clock
    input wire logic clk,
    // Host write and read
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [7:0] host_addr,
    output logic [31:0] host_data,
    // Pixel lookup
    input wire logic [7:0] pix_addr,
    output logic [31:0] pix_data
);

    logic [31:0] mem [TABLE_DEPTH];

    // Write port; contents are undefined until software loads them
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Both read ports registered so the host never stalls the pixel path
    always_ff @(posedge clk) begin
        host_data <= mem[host_addr];
        pix_data <= mem[pix_addr];
    end

endmodule

/* testbench/layer_color_key_and_palette_checker.sv */
// Concurrent checks on the register port and the composited pixel output
`timescale 1ns/1ps
module layer_color_key_and_palette_checker
    import layer_key_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [12:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Pixel path
    input wire logic pixel_valid,
    input wire layer_pixel_t [NUM_LAYERS-1:0] pixel_in,
    input wire logic [NUM_LAYERS-1:0] blend_on,
    input wire out_pixel_t pixel_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Host read that lands in one of the four colour tables
    logic tbl_rd;
    assign tbl_rd = reg_read && (reg_addr[12:10] inside {3'h1, 3'h2, 3'h4, 3'h5});

    // Read answers stand one cycle only, so stale data never leaks onto the bus
    a_rdata_idle_zero:
    assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    a_key_reserved_zero:
    assert property (reg_read && reg_addr >= KEY_L1_OFFSET && reg_addr <= KEY_L5_OFFSET
        |=> reg_rdata[30:24] == 7'h00) else $error("key register reserved bits not zero");
    a_table_loose_zero:
    assert property (tbl_rd |=> (reg_rdata & ~TABLE_KEEP_MASK) == 32'h0000_0000)
        else $error("colour table unused bits not zero");
    a_short_upper_zero:
    assert property (reg_read && (reg_addr == SHORT_L2_OFFSET || reg_addr == SHORT_L3_OFFSET)
        |=> reg_rdata[31:16] == 16'h0000) else $error("short key view upper half not zero");
    a_low_unmapped:
    assert property (reg_read && reg_addr < SHORT_L3_OFFSET |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read gave data");
    // Output valid follows input valid through the two-stage pipe
    a_pixel_latency:
    assert property (pixel_out.valid == $past(pixel_valid, 2))
        else $error("pixel output valid not two cycles after input");
    a_blend_gated:
    assert property (pixel_out.valid && pixel_out.blend
        |-> (($past(blend_on) >> pixel_out.layer) & 6'h01) == 6'h01)
        else $error("blend shown for a layer with blending off");
    a_upper_code:
    assert property (pixel_out.valid && pixel_out.layer >= 3'h4 |-> pixel_out.colour ==
        (pixel_out.layer == 3'h5 ? $past(pixel_in[5].code, 2) : $past(pixel_in[4].code, 2)))
        else $error("layer without colour table did not show its code");
    a_ycbcr_shown:
    assert property (pixel_valid && pixel_in[1].ycbcr |-> ##2 pixel_out.layer != 3'h0)
        else $error("YCbCr pixel of layer 1 treated as transparent");

    // Main scenarios reached
    c_table_read: cover property (tbl_rd);
    c_blend_out: cover property (pixel_out.valid && pixel_out.blend);
    c_background: cover property (pixel_out.valid && pixel_out.layer == 3'h0);
endmodule

bind layer_color_key_and_palette layer_color_key_and_palette_checker u_checker (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pixel_valid(pixel_valid), .pixel_in(pixel_in), .blend_on(blend_on),
    .pixel_out(pixel_out)
);

/* testbench/layer_color_key_and_palette_bench.sv */
// Self-checking bench for key colour transparency and colour table lookup
`timescale 1ns/1ps
module layer_color_key_and_palette_bench;
    import layer_key_pkg::*;

    typedef struct {
        logic [12:0] wa;
        logic [31:0] wd;
        logic [12:0] ra;
        logic [31:0] ex;
    } reg_row_t;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [12:0] reg_addr = 13'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic pixel_valid = 1'b0;
    layer_pixel_t [NUM_LAYERS-1:0] pixel_in = '0;
    logic [NUM_LAYERS-1:0] blend_on = 6'h00;
    out_pixel_t pixel_out;
    layer_pixel_t [NUM_LAYERS-1:0] pv;
    int fails = 0;
    int checks_done = 0;
    // Write then read back, possibly through the other view of the same storage
    reg_row_t rows [14] = '{
        '{13'h01a4, 32'h7fff_ffff, 13'h01a4, 32'h00ff_ffff},
        '{13'h01a8, 32'h7f00_0000, 13'h01a8, 32'h0000_0000},
        '{13'h01ac, 32'h80ab_cdef, 13'h00c0, 32'h0000_cdef},
        '{13'h00c0, 32'h0000_1234, 13'h01ac, 32'h00ab_9234},
        '{13'h01b0, 32'h0000_0001, 13'h01b0, 32'h0000_0001},
        '{13'h01b4, 32'h0012_3456, 13'h01b4, 32'h0012_3456},
        '{13'h0414, 32'hffff_ffff, 13'h0414, 32'h80fc_fcfc},
        '{13'h07fc, 32'h0000_0303, 13'h07fc, 32'h0000_0000},
        '{13'h0800, 32'h8012_3400, 13'h0800, 32'h8010_3400},
        '{13'h1000, 32'h00aa_bb44, 13'h1000, 32'h00a8_b844},
        '{13'h1040, 32'h8004_0800, 13'h1040, 32'h8004_0800},
        '{13'h16a8, 32'h0000_fc00, 13'h16a8, 32'h0000_fc00},
        '{13'h17fc, 32'h8000_0004, 13'h17fc, 32'h8000_0004},
        '{13'h0000, 32'hffff_ffff, 13'h0000, 32'h0000_0000}
    };

    layer_color_key_and_palette u_layer_color_key_and_palette (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .pixel_valid(pixel_valid), .pixel_in(pixel_in), .blend_on(blend_on),
        .pixel_out(pixel_out)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    function automatic layer_pixel_t px(input logic i, input logic y, input logic a,
                                        input logic [23:0] c);
        px = '{i, y, a, c};
    endfunction

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pix(input out_pixel_t got, input out_pixel_t exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: pixel %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Bus cycles, entered just after a rising edge
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [12:0] a, input logic [31:0] e);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk_reg(reg_rdata, e);
        @(posedge clk);
    endtask

    // One pixel through the pipe; blend enables held until it is judged
    task automatic pix(input logic [5:0] b, input logic [2:0] l, input logic bl,
                       input logic [23:0] c);
        pixel_in <= pv;
        blend_on <= b;
        pixel_valid <= 1'b1;
        @(posedge clk);
        pixel_valid <= 1'b0;
        pixel_in <= '0;
        // Output register loads at the next edge and stands one cycle only
        @(posedge clk);
        #1 chk_pix(pixel_out, '{1'b1, l, bl, c});
        @(posedge clk);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(KEY_L1_OFFSET + 13'(4 * i), 32'h0000_0000);
        end
        rd(SHORT_L2_OFFSET, 32'h0000_0000);
        $display("register reset test done");
        for (int i = 0; i < 14; i++) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].ex);
        end
        $display("register table test done");
        // Everything above layer 0 keyed out by code zero
        pv = '0;
        pv[0] = px(1'b1, 1'b0, 1'b0, 24'h00_0005);
        pix(6'h01, 3'h0, 1'b1, 24'hfc_fcfc);
        // Full 24-bit key match hides layer 5
        pv = '0;
        pv[5] = px(1'b0, 1'b0, 1'b0, 24'h12_3456);
        pv[4] = px(1'b0, 1'b0, 1'b1, 24'h00_abcd);
        pix(6'h10, 3'h4, 1'b1, 24'h00_abcd);
        // Indirect code matches only the low key byte
        pv = '0;
        pv[3] = px(1'b1, 1'b0, 1'b0, 24'h00_0034);
        pv[2] = px(1'b1, 1'b0, 1'b0, 24'h00_0010);
        pix(6'h00, 3'h2, 1'b0, 24'h04_0800);
        // Entry without blend permission stays unblended
        pv[3] = px(1'b1, 1'b0, 1'b0, 24'h00_00aa);
        pix(6'h08, 3'h3, 1'b0, 24'h00_fc00);
        // YCbCr ignores a matching key; the same code keyed out otherwise
        pv = '0;
        pv[0] = px(1'b0, 1'b0, 1'b0, 24'h00_0777);
        pv[1] = px(1'b0, 1'b1, 1'b0, 24'hff_ffff);
        pix(6'h00, 3'h1, 1'b0, 24'hff_ffff);
        pv[1] = px(1'b0, 1'b0, 1'b0, 24'hff_ffff);
        pix(6'h00, 3'h0, 1'b0, 24'h00_0777);
        // Zero code made opaque through the short view
        wr(SHORT_L2_OFFSET, 32'h0000_8000);
        rd(KEY_L2_OFFSET, 32'h8000_0000);
        pv = '0;
        pv[2] = px(1'b1, 1'b0, 1'b0, 24'h00_0000);
        pix(6'h00, 3'h2, 1'b0, 24'ha8_b844);
        $display("pixel tests done");
        // Mid-run reset must clear keys and zero-code bits again
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(KEY_L2_OFFSET, 32'h0000_0000);
        rd(SHORT_L3_OFFSET, 32'h0000_0000);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule
